// File: core/aspr_device.sv
// Converter end: serial register port, ready flag, master clock and filter.
module aspr_device (
    // Clock and reset.
    input  wire logic                         core_clk_in,
    input  wire logic                         reset_in,
    // Serial link.
    aspr_if.dev                               link,
    // Master clock pins.
    input  wire logic                         crystal_in_pin_in,
    input  wire logic                         master_clock_pin_in,
    output logic                              master_clock_pin_out,
    output logic                              master_clock_pin_oe_out,
    // Modulator side.
    input  wire logic [aspr_pkg::WORD_W-1:0]  sample_in,
    output logic                              modulator_reset_out,
    output logic                              conv_done_out
);

    localparam int SYN_W = 6;

    logic [SYN_W-1:0]                   syn1_reg;
    logic [SYN_W-1:0]                   syn2_reg;
    logic                               sclk_s;
    logic                               cs_n_s;
    logic                               din_s;
    logic                               sync_n_s;
    logic                               xtal_s;
    logic                               mpin_s;
    logic                               sclk_d_reg;
    logic                               sclk_rise;
    logic                               sclk_fall;

    logic                               data_phase_reg;
    logic [aspr_pkg::CNT_W-1:0]         cnt_reg;
    logic [aspr_pkg::COMM_W-1:0]        comm_reg;
    logic [aspr_pkg::COMM_W-1:0]        comm_next;
    logic [aspr_pkg::WORD_W-1:0]        in_shift_reg;
    logic [aspr_pkg::WORD_W-1:0]        in_word_next;
    logic [aspr_pkg::WORD_W-1:0]        out_word_reg;
    logic                               rd_reg;
    logic [aspr_pkg::SEL_W-1:0]         sel_reg;
    logic [aspr_pkg::SEL_W-1:0]         sel_next;
    logic                               dout_reg;
    logic                               last_bit;
    logic                               write_done;
    logic                               read_done;

    logic [aspr_pkg::WORD_W-1:0]        reg_file [aspr_pkg::REG_CNT];
    logic [1:0]                         clk_sel;

    logic [aspr_pkg::DIV_W-1:0]         div_reg;
    logic                               int_clk_reg;
    logic                               mclk_sel;
    logic                               mclk_d_reg;
    logic                               mclk_tick;
    logic [aspr_pkg::CONV_CNT_W-1:0]    conv_cnt_reg;
    logic [aspr_pkg::ACC_W-1:0]         acc_reg;
    logic [aspr_pkg::ACC_W-1:0]         acc_next;
    logic                               conv_done;
    logic                               rdy_pre;
    logic                               rdy_n_reg;

    // Every pin from the host and every external clock passes two flip-flops first.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            syn1_reg <= 6'h3F;
            syn2_reg <= 6'h3F;
        end else begin
            syn1_reg <= {link.sclk, link.cs_n, link.din, link.sync_n, crystal_in_pin_in, master_clock_pin_in};
            syn2_reg <= syn1_reg;
        end
    end

    assign sclk_s   = syn2_reg[5];
    assign cs_n_s   = syn2_reg[4];
    assign din_s    = syn2_reg[3];
    assign sync_n_s = syn2_reg[2];
    assign xtal_s   = syn2_reg[1];
    assign mpin_s   = syn2_reg[0];

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sclk_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;

    assign comm_next    = {comm_reg[aspr_pkg::COMM_W-2:0], din_s};
    assign in_word_next = {in_shift_reg[aspr_pkg::WORD_W-2:0], din_s};
    assign sel_next     = comm_next[aspr_pkg::COMM_SEL_LSB +: aspr_pkg::SEL_W];
    assign last_bit     = (cnt_reg == aspr_pkg::CNT_W'(aspr_pkg::WORD_W - 1));
    assign write_done   = sclk_rise & data_phase_reg & ~rd_reg & last_bit;
    assign read_done    = sclk_rise & data_phase_reg & rd_reg & last_bit & (sel_reg == aspr_pkg::REG_DATA);

    // Frame state moves only on serial clock edges, so a paused clock keeps it.
    // Chip select high abandons the frame; tied low the port runs on three wires.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || cs_n_s) begin
            data_phase_reg <= 1'b0;
            cnt_reg        <= '0;
            comm_reg       <= '0;
            in_shift_reg   <= '0;
            out_word_reg   <= '0;
            rd_reg         <= 1'b0;
            sel_reg        <= '0;
        end else if (sclk_rise) begin
            if (!data_phase_reg) begin
                comm_reg <= comm_next;
                if (cnt_reg == aspr_pkg::CNT_W'(aspr_pkg::COMM_W - 1)) begin
                    data_phase_reg <= 1'b1;
                    cnt_reg        <= '0;
                    rd_reg         <= comm_next[aspr_pkg::COMM_RD_BIT];
                    sel_reg        <= sel_next;
                    out_word_reg   <= reg_file[sel_next];
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            end else begin
                in_shift_reg <= in_word_next;
                if (last_bit) begin
                    data_phase_reg <= 1'b0;
                    cnt_reg        <= '0;
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            end
        end
    end

    // Output bit changes only on a falling edge, ahead of the host's rising sample.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || cs_n_s) begin
            dout_reg <= 1'b1;
        end else if (sclk_fall && data_phase_reg && rd_reg) begin
            dout_reg <= out_word_reg[5'(aspr_pkg::WORD_W - 1) - cnt_reg];
        end
    end

    // Outside a read the pin shows the ready flag; released while deselected.
    assign link.dout_drv = (data_phase_reg && rd_reg) ? dout_reg : rdy_n_reg;
    assign link.dout_oe  = ~cs_n_s;

    // Register file; the data entry is loaded by conversions, never by the host.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < aspr_pkg::REG_CNT; i++) begin
                reg_file[i] <= aspr_pkg::REG_RESET;
            end
        end else begin
            if (write_done && sel_reg != aspr_pkg::REG_DATA) begin
                reg_file[sel_reg] <= in_word_next;
            end
            if (conv_done) begin
                reg_file[aspr_pkg::REG_DATA] <= acc_next[aspr_pkg::ACC_W-1 -: aspr_pkg::WORD_W];
            end
        end
    end

    assign clk_sel = reg_file[aspr_pkg::REG_MODE][aspr_pkg::MODE_CLK_LSB +: 2];

    // Internal master clock, divided down from the core clock.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            div_reg     <= '0;
            int_clk_reg <= 1'b0;
        end else if (div_reg == aspr_pkg::DIV_W'(aspr_pkg::INT_DIV_HALF - 1)) begin
            div_reg     <= '0;
            int_clk_reg <= ~int_clk_reg;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign master_clock_pin_out    = int_clk_reg;
    assign master_clock_pin_oe_out = (clk_sel == aspr_pkg::CLK_INT_OUT);

    // Source choice: internal, crystal across both pins, or logic clock on the master pin.
    always_comb begin
        unique case (clk_sel)
            aspr_pkg::CLK_INT:     mclk_sel = int_clk_reg;
            aspr_pkg::CLK_INT_OUT: mclk_sel = int_clk_reg;
            aspr_pkg::CLK_XTAL:    mclk_sel = xtal_s;
            aspr_pkg::CLK_EXT:     mclk_sel = mpin_s;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mclk_d_reg <= 1'b0;
        end else begin
            mclk_d_reg <= mclk_sel;
        end
    end

    // An external master clock must stay well below half the core rate to be seen.
    assign mclk_tick = mclk_sel & ~mclk_d_reg;
    assign acc_next  = acc_reg + aspr_pkg::ACC_W'(sample_in);
    assign conv_done = mclk_tick & sync_n_s & (conv_cnt_reg == 8'(aspr_pkg::CONV_MCLKS - 1));
    assign rdy_pre   = mclk_tick & (conv_cnt_reg == 8'(aspr_pkg::CONV_MCLKS - 1 - aspr_pkg::RDY_PRE_MCLKS));

    // Boxcar filter and its sequencing, held cleared while sync is low.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !sync_n_s) begin
            conv_cnt_reg <= '0;
            acc_reg      <= '0;
        end else if (mclk_tick) begin
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
            acc_reg      <= conv_done ? '0 : acc_next;
        end
    end

    assign modulator_reset_out = ~sync_n_s;
    assign conv_done_out       = conv_done;

    // A fresh result wins over any clear in the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdy_n_reg <= 1'b1;
        end else if (conv_done) begin
            rdy_n_reg <= 1'b0;
        end else if (!sync_n_s) begin
            rdy_n_reg <= 1'b1;
        end else if (rdy_pre) begin
            rdy_n_reg <= 1'b1;
        end else if (read_done) begin
            rdy_n_reg <= 1'b1;
        end
    end

endmodule // aspr_device

// File: core/aspr_pkg.sv
// Shared constants and types for both ends of the converter serial port.
package aspr_pkg;

    // Serial word layout.
    localparam int WORD_W       = 24;
    localparam int COMM_W       = 8;
    localparam int FRAME_BITS   = COMM_W + WORD_W;
    localparam int REG_CNT      = 8;
    localparam int SEL_W        = 3;
    localparam int CNT_W        = 5;
    localparam int COMM_RD_BIT  = 6;
    localparam int COMM_SEL_LSB = 3;

    // Register indices.
    localparam logic [SEL_W-1:0] REG_MODE = 3'h1;
    localparam logic [SEL_W-1:0] REG_DATA = 3'h3;

    // Mode register fields and reset value.
    localparam int               MODE_CLK_LSB = 0;
    localparam logic [1:0]       CLK_INT      = 2'h0;
    localparam logic [1:0]       CLK_INT_OUT  = 2'h1;
    localparam logic [1:0]       CLK_XTAL     = 2'h2;
    localparam logic [1:0]       CLK_EXT      = 2'h3;
    localparam logic [WORD_W-1:0] REG_RESET   = 24'h000000;

    // Clock rates and derived counts.
    localparam int CORE_PERIOD_NS = 10;
    localparam int CORE_CLK_KHZ   = 100000;
    localparam int INT_MCLK_KHZ   = 4920;
    localparam int INT_DIV_HALF   = CORE_CLK_KHZ / (2 * INT_MCLK_KHZ);
    localparam int DIV_W          = 4;

    // Conversion timing in master clock periods.
    localparam int CONV_CNT_W     = 8;
    localparam int CONV_MCLKS     = 256;
    localparam int RDY_PRE_MCLKS  = 4;
    localparam int ACC_W          = WORD_W + CONV_CNT_W;

    // Host serial clock.
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_LEAD,
        HOST_SHIFT,
        HOST_TAIL
    } aspr_host_state_t;

endpackage : aspr_pkg

// File: core/aspr_if.sv
// Serial link between the converter port and its host controller.
interface aspr_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic sync_n;
    logic dout_drv;
    logic dout_oe;
    logic dout;

    // A released line is pulled high, so an idle bus reads as not ready.
    assign dout = dout_oe ? dout_drv : 1'b1;

    modport dev (
        input  sclk,
        input  cs_n,
        input  din,
        input  sync_n,
        output dout_drv,
        output dout_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output din,
        output sync_n,
        input  dout
    );
endinterface : aspr_if

// File: core/aspr_host.sv
// Host end: drives serial clock, chip select, data in and sync; reads results.
module aspr_host (
    // Clock and reset.
    input  wire logic                            core_clk_in,
    input  wire logic                            reset_in,
    // Serial link.
    aspr_if.host                                 link,
    // Transfer request.
    input  wire logic                            start_in,
    input  wire logic                            read_in,
    input  wire logic [aspr_pkg::SEL_W-1:0]      sel_in,
    input  wire logic [aspr_pkg::WORD_W-1:0]     wr_data_in,
    input  wire logic                            three_wire_in,
    input  wire logic                            sync_req_in,
    // Transfer result.
    output logic                                 busy_out,
    output logic                                 done_out,
    output logic [aspr_pkg::WORD_W-1:0]          rd_data_out,
    output logic                                 data_ready_out,
    output logic                                 data_ready_irq_out
);

    aspr_pkg::aspr_host_state_t         state_reg;
    logic [3:0]                         half_reg;
    logic                               half_end;
    logic [5:0]                         bit_reg;
    logic [aspr_pkg::FRAME_BITS-1:0]    tx_reg;
    logic [aspr_pkg::WORD_W-1:0]        rx_reg;
    logic                               sclk_reg;
    logic                               cs_n_reg;
    logic                               din_reg;
    logic                               sync_n_reg;
    logic                               dout1_reg;
    logic                               dout2_reg;
    logic                               ready_d_reg;
    logic [aspr_pkg::COMM_W-1:0]        comm;

    always_comb begin
        comm                                              = 8'h00;
        comm[aspr_pkg::COMM_RD_BIT]                       = read_in;
        comm[aspr_pkg::COMM_SEL_LSB +: aspr_pkg::SEL_W]   = sel_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            dout1_reg <= 1'b1;
            dout2_reg <= 1'b1;
        end else begin
            dout1_reg <= link.dout;
            dout2_reg <= dout1_reg;
        end
    end

    assign half_end = (half_reg == 4'(aspr_pkg::SCLK_HALF_CYC - 1));

    // Chip select frames each transfer, or stays low for three-wire use.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_reg <= aspr_pkg::HOST_IDLE;
            half_reg  <= '0;
            bit_reg   <= '0;
            tx_reg    <= '0;
            rx_reg    <= '0;
            sclk_reg  <= 1'b1;
            cs_n_reg  <= 1'b1;
            din_reg   <= 1'b1;
        end else begin
            half_reg <= half_end ? 4'h0 : half_reg + 4'h1;
            unique case (state_reg)
                aspr_pkg::HOST_IDLE: begin
                    cs_n_reg <= ~three_wire_in;
                    half_reg <= '0;
                    if (start_in) begin
                        tx_reg    <= {comm, wr_data_in};
                        bit_reg   <= '0;
                        cs_n_reg  <= 1'b0;
                        state_reg <= aspr_pkg::HOST_LEAD;
                    end
                end
                aspr_pkg::HOST_LEAD: begin
                    if (half_end) begin
                        state_reg <= aspr_pkg::HOST_SHIFT;
                    end
                end
                aspr_pkg::HOST_SHIFT: begin
                    if (half_end && sclk_reg) begin
                        sclk_reg <= 1'b0;
                        din_reg  <= tx_reg[aspr_pkg::FRAME_BITS-1];
                        tx_reg   <= {tx_reg[aspr_pkg::FRAME_BITS-2:0], 1'b0};
                    end else if (half_end) begin
                        sclk_reg <= 1'b1;
                        rx_reg   <= {rx_reg[aspr_pkg::WORD_W-2:0], dout2_reg};
                        bit_reg  <= bit_reg + 6'h01;
                        if (bit_reg == 6'(aspr_pkg::FRAME_BITS - 1)) begin
                            state_reg <= aspr_pkg::HOST_TAIL;
                        end
                    end
                end
                aspr_pkg::HOST_TAIL: begin
                    if (half_end) begin
                        cs_n_reg  <= ~three_wire_in;
                        din_reg   <= 1'b1;
                        state_reg <= aspr_pkg::HOST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            done_out    <= 1'b0;
            rd_data_out <= '0;
        end else begin
            done_out <= (state_reg == aspr_pkg::HOST_TAIL) && half_end;
            if ((state_reg == aspr_pkg::HOST_TAIL) && half_end) begin
                rd_data_out <= rx_reg;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync_n_reg  <= 1'b1;
            ready_d_reg <= 1'b0;
        end else begin
            sync_n_reg  <= ~sync_req_in;
            ready_d_reg <= data_ready_out;
        end
    end

    // Ready is only visible while selected and idle; its falling pin edge is the interrupt.
    assign data_ready_out     = (state_reg == aspr_pkg::HOST_IDLE) & ~cs_n_reg & ~dout2_reg;
    assign data_ready_irq_out = data_ready_out & ~ready_d_reg;
    assign busy_out           = (state_reg != aspr_pkg::HOST_IDLE);
    assign link.sclk          = sclk_reg;
    assign link.cs_n          = cs_n_reg;
    assign link.din           = din_reg;
    assign link.sync_n        = sync_n_reg;

endmodule // aspr_host

// File: tb/aspr_link_properties.sv
// Concurrent checks on the serial link between the converter port and its host.
module aspr_link_properties (
    // Clock and reset.
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    // Link signals.
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic din,
    input  wire logic sync_n,
    input  wire logic dout_drv,
    input  wire logic dout_oe,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // Falls of the serial clock in the current frame; deselect clears it.
    logic [5:0] fall_cnt_reg;

    always_ff @(posedge core_clk_in) begin
        if (reset_in || cs_n) begin
            fall_cnt_reg <= 6'h00;
        end else if ($fell(sclk)) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end

    sequence s_low_phase;
        (!sclk)[*4] ##[1:8] sclk;
    endsequence

    AST_CS_FALL_IDLE: assert property ($fell(cs_n) |-> sclk)
        else $error("chip select fell with serial clock low");
    AST_SCLK_IN_FRAME: assert property ($fell(sclk) |-> !cs_n)
        else $error("serial clock fell outside a frame");
    // Data in moves with the falling edge, so it must be settled when the device samples.
    AST_DIN_SETTLED: assert property ($rose(sclk) |-> $stable(din))
        else $error("data in changed at a rising serial clock edge");
    AST_LOW_PHASE: assert property ($fell(sclk) |-> s_low_phase)
        else $error("serial clock low phase too short or too long");
    AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
        else $error("output not driven after select");
    AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
        else $error("output not released after deselect");
    AST_IDLE_PULLUP: assert property (cs_n[*4] |-> !dout_oe && dout)
        else $error("output driven while deselected");
    AST_FRAME_LEN: assert property ($rose(cs_n) |-> fall_cnt_reg == 6'h20)
        else $error("frame did not carry 32 clocks");
    AST_SYNC_READY: assert property ((!sync_n)[*6] |-> dout_drv)
        else $error("ready stayed low during sync");
    // A conversion cannot finish while the filter is held, so a fall needs sync high.
    AST_READY_FALL: assert property ($fell(dout_drv) |-> sync_n && $past(sync_n, 4))
        else $error("ready fell while sync was low");
endmodule // aspr_link_properties

// File: tb/testbench.sv
// Self-checking bench joining the converter port and its host across the link.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [23:0] SAMPLE = 24'h3C5A96;

    logic        core_clk;
    logic        reset;
    logic        ext_clk;
    logic        start;
    logic        rd;
    logic [2:0]  sel;
    logic [23:0] wdata;
    logic        three_wire;
    logic        sync_req;
    logic        busy;
    logic        done;
    logic [23:0] rd_data;
    logic        ready;
    logic        ready_irq;
    logic        mclk_out;
    logic        mclk_oe;
    logic        mod_reset;
    logic        conv_done;
    int          bad_count = 0;
    int          comparisons = 0;

    aspr_if u_aspr_if ();

    aspr_device u_aspr_device (.core_clk_in(core_clk), .reset_in(reset), .link(u_aspr_if.dev),
        .crystal_in_pin_in(ext_clk), .master_clock_pin_in(ext_clk), .master_clock_pin_out(mclk_out),
        .master_clock_pin_oe_out(mclk_oe), .sample_in(SAMPLE), .modulator_reset_out(mod_reset),
        .conv_done_out(conv_done));

    aspr_host u_aspr_host (.core_clk_in(core_clk), .reset_in(reset), .link(u_aspr_if.host),
        .start_in(start), .read_in(rd), .sel_in(sel), .wr_data_in(wdata), .three_wire_in(three_wire),
        .sync_req_in(sync_req), .busy_out(busy), .done_out(done), .rd_data_out(rd_data),
        .data_ready_out(ready), .data_ready_irq_out(ready_irq));

    aspr_link_properties u_aspr_link_properties (.core_clk_in(core_clk), .reset_in(reset),
        .sclk(u_aspr_if.sclk), .cs_n(u_aspr_if.cs_n), .din(u_aspr_if.din), .sync_n(u_aspr_if.sync_n),
        .dout_drv(u_aspr_if.dout_drv), .dout_oe(u_aspr_if.dout_oe), .dout(u_aspr_if.dout));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        ext_clk = 1'b0;
        forever #100 ext_clk = ~ext_clk;
    end

    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic ran_out();
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        give_verdict();
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    // Inputs always move one nanosecond after the rising edge, clear of sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_ready(input logic lvl, output int n);
        for (n = 0; n < 12000 && ready !== lvl; n++) tick(1);
        if (n == 12000) ran_out();
    endtask

    task automatic xfer(input logic r, input logic [2:0] s, input logic [23:0] w, output logic [23:0] q);
        int n;
        start = 1'b1;
        rd = r;
        sel = s;
        wdata = w;
        tick(1);
        start = 1'b0;
        check_bit(busy, 1'b1, "not busy after start");
        for (n = 0; n < 2000 && done !== 1'b1; n++) tick(1);
        if (n == 2000) ran_out();
        q = rd_data;
        check_bit(busy, 1'b0, "still busy after done");
        tick(1);
    endtask

    task automatic t_regs();
        logic [23:0] q;
        for (int i = 2; i < 8; i++) if (i != 3) xfer(1'b0, 3'(i), 24'hA5C300 | 24'(i), q);
        for (int i = 2; i < 8; i++) begin
            if (i != 3) begin
                xfer(1'b1, 3'(i), 24'h000000, q);
                check_word(q, 24'hA5C300 | 24'(i), "register readback");
            end
        end
        xfer(1'b0, aspr_pkg::REG_DATA, 24'h123456, q);
        xfer(1'b1, aspr_pkg::REG_DATA, 24'h000000, q);
        check_word(q, SAMPLE, "data register took a write");
        $display("test register readback done");
    endtask

    task automatic t_ready_read();
        logic [23:0] q;
        int n;
        three_wire = 1'b1;
        xfer(1'b0, 3'h2, 24'hA5C302, q);
        wait_ready(1'b1, n);
        check_bit(ready_irq, 1'b1, "no interrupt on ready fall");
        xfer(1'b1, aspr_pkg::REG_DATA, 24'h000000, q);
        check_word(q, SAMPLE, "conversion result");
        tick(4);
        check_bit(ready, 1'b0, "ready still low after full read");
        $display("test ready and read done");
    endtask

    task automatic t_unread();
        int n1;
        int n2;
        wait_ready(1'b1, n1);
        wait_ready(1'b0, n1);
        wait_ready(1'b1, n2);
        check_bit(n1 > 4000, 1'b1, "unread ready cleared too early");
        check_bit(n2 >= 60 && n2 <= 100, 1'b1, "ready high gap before update");
        $display("test unread result done");
    endtask

    task automatic t_sync();
        logic [23:0] q;
        int n;
        wait_ready(1'b1, n);
        sync_req = 1'b1;
        tick(8);
        check_bit(ready, 1'b0, "sync left ready low");
        check_bit(mod_reset, 1'b1, "modulator not held in reset");
        sync_req = 1'b0;
        tick(8);
        check_bit(mod_reset, 1'b0, "modulator reset stuck");
        xfer(1'b1, 3'h2, 24'h000000, q);
        check_word(q, 24'hA5C302, "register lost across sync");
        wait_ready(1'b1, n);
        check_bit(n > 4000, 1'b1, "filter not restarted by sync");
        $display("test sync done");
    endtask

    task automatic t_clocks();
        logic [23:0] q;
        logic        last;
        int          t;
        int          n;
        for (int m = 0; m < 4; m++) begin
            xfer(1'b0, aspr_pkg::REG_MODE, 24'(m), q);
            xfer(1'b1, aspr_pkg::REG_MODE, 24'h000000, q);
            check_word(q, 24'(m), "mode readback");
            check_bit(mclk_oe, m == 1, "master pin drive enable");
            t = 0;
            last = mclk_out;
            repeat (100) begin
                tick(1);
                if (mclk_out !== last) t++;
                last = mclk_out;
            end
            if (m == 1) check_bit(t >= 9 && t <= 11, 1'b1, "internal clock rate on pin");
            for (n = 0; n < 12000 && conv_done !== 1'b1; n++) tick(1);
            check_bit(n < 12000, 1'b1, "no conversion on this clock source");
        end
        $display("test clock sources done");
    endtask

    initial begin
        reset = 1'b1;
        start = 1'b0;
        rd = 1'b0;
        sel = 3'h0;
        wdata = 24'h000000;
        three_wire = 1'b0;
        sync_req = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        reset = 1'b0;
        tick(8);
        t_regs();
        t_ready_read();
        t_unread();
        t_sync();
        t_clocks();
        give_verdict();
    end
endmodule // testbench
